// ---- src/fsr_pkg.sv ----
// fsr_pkg: constants and carriers for the flash suspend/resume sequencer
// assumes a 10 MHz system clock and a serial link clocked by the host
package fsr_pkg;
   // ****************************************
   // commands
   // ****************************************
   localparam logic [7:0] FSR_OP_ERS_SUSP  = 8'h75;
   localparam logic [7:0] FSR_OP_ERS_RESUM = 8'h7A;
   localparam logic [7:0] FSR_OP_PGM_SUSP  = 8'h85;
   localparam logic [7:0] FSR_OP_PGM_RESUM = 8'h8A;
   // ****************************************
   // parameter dword fields
   // ****************************************
   localparam logic       FSR_SUSP_SUPPORTED = 1'h0;
   localparam logic [1:0] FSR_UNIT_128NS     = 2'h0;
   localparam logic [1:0] FSR_UNIT_1US       = 2'h1;
   localparam logic [1:0] FSR_UNIT_8US       = 2'h2;
   localparam logic [1:0] FSR_UNIT_64US      = 2'h3;
   localparam logic [4:0] FSR_ERS_LAT_CNT    = 5'h04;
   localparam logic [3:0] FSR_ERS_INTV_CNT   = 4'h1;
   localparam logic [4:0] FSR_PGM_LAT_CNT    = 5'h04;
   localparam logic [3:0] FSR_PGM_INTV_CNT   = 4'h1;
   localparam logic       FSR_RFU_BIT        = 1'h1;
   localparam logic [3:0] FSR_ERS_PROHIB     = 4'hE;
   localparam logic [3:0] FSR_PGM_PROHIB     = 4'hC;
   localparam logic [31:0] FSR_DWORD = {FSR_SUSP_SUPPORTED, FSR_UNIT_8US, FSR_ERS_LAT_CNT,
                                        FSR_ERS_INTV_CNT, FSR_UNIT_8US, FSR_PGM_LAT_CNT,
                                        FSR_PGM_INTV_CNT, FSR_RFU_BIT, FSR_ERS_PROHIB,
                                        FSR_PGM_PROHIB};
   localparam logic [7:0] FSR_DISC_BASE = 8'h2C;
   localparam logic [7:0] FSR_ALT_BASE  = 8'h2E;
   // ****************************************
   // timing
   // ****************************************
   localparam int FSR_CLK_MHZ     = 10;
   localparam int FSR_SUSP_LAT_US = 40;
   // suspend settles a little inside the advertised maximum (longest time rounds down)
   localparam int FSR_SUSP_CYC    = (FSR_SUSP_LAT_US * FSR_CLK_MHZ) - 8;
   localparam logic [8:0] FSR_SUSP_CYC_W = 9'(FSR_SUSP_CYC);
   // ****************************************
   // carriers
   // ****************************************
   typedef enum {FSR_IDLE, FSR_ERS_BUSY, FSR_ERS_SUSPING, FSR_ERS_SUSP,
                 FSR_PGM_BUSY, FSR_PGM_SUSPING, FSR_PGM_SUSP} fsr_state_t;
   typedef struct packed {
      logic       ers_susp;
      logic       pgm_susp;
      logic       busy;
   } fsr_stat_t;
endpackage : fsr_pkg

// ---- src/fsr_seq.sv ----
// fsr_seq: erase/program suspend-resume sequencer and parameter dword reader
// assumes the host drives a serial clock, chip select and one data line in, mode 0
//
// Contract
// R1: erase suspend reached within 40 us
// R2: host waits 128 us before re-suspending erase
// R3: program suspend reached within 40 us
// R4: host waits 128 us before re-suspending program
// R5: no new erase during erase suspend
// R6: no read of erase-suspended sector
// R7: no erase or program during program suspend
// R8: no read of program-suspended page
// R9: bit 31 zero, suspend supported
// R10: latency units 8 us for both
// R11: discoverable offsets 2Ch-2Fh return dword bytes
// R12: alternate offsets 2Eh-31h return same bytes
// R13: decode 75h erase suspend, 7Ah resume
// R14: decode 85h program suspend
// R15: host confirms suspend before next command
`timescale 1ns/1ps
`default_nettype none
module fsr_seq
   import fsr_pkg::*;
(
   // system
   input  wire logic       i_sys_clk,
   input  wire logic       i_srst,
   // serial link
   input  wire logic       i_sck,
   input  wire logic       i_cs_n,
   input  wire logic       i_si,
   // array engine
   input  wire logic       i_ers_start,
   input  wire logic       i_pgm_start,
   input  wire logic       i_op_done,
   // parameter table read
   input  wire logic [7:0] i_tbl_addr,
   input  wire logic       i_tbl_alt,
   output logic      [7:0] o_tbl_data,
   output logic            o_tbl_hit,
   // status
   output fsr_stat_t       o_stat
);
   // ****************************************
   // link domain: shift in opcode
   // ****************************************
   logic [7:0] sh_r;
   logic [2:0] bcnt_r;
   logic [7:0] op_r;
   logic       op_tgl_r;
   localparam logic [2:0] LAST_BIT    = 3'h7;
   localparam logic [7:0] DWORD_BYTES = 8'h04;
   // frame signal clears the counter so a stopped clock leaves nothing pending
   always_ff @(posedge i_sck or posedge i_cs_n) begin
      if (i_cs_n) begin
         bcnt_r <= 3'h0;
         sh_r   <= 8'h00;
      end else begin
         sh_r   <= {sh_r[6:0], i_si};
         bcnt_r <= bcnt_r + 3'h1;
      end
   end
   // the link clock stands still between frames, so this side takes the
   // system reset without it; a reset in mid-frame loses that opcode only
   always_ff @(posedge i_sck or posedge i_srst) begin
      if (i_srst) begin
         op_r     <= 8'h00;
         op_tgl_r <= 1'b0;
      end else if (!i_cs_n && bcnt_r == LAST_BIT) begin
         op_r     <= {sh_r[6:0], i_si};
         op_tgl_r <= ~op_tgl_r;
      end
   end
   // ****************************************
   // crossing: toggle sync, opcode held stable
   // ****************************************
   logic [2:0] tgl_s_r;
   logic       cmd_vld;
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         tgl_s_r <= 3'h0;
      end else begin
         tgl_s_r <= {tgl_s_r[1:0], op_tgl_r};
      end
   end
   // a toggle, not a pulse: the link clock is faster and a pulse would be missed
   assign cmd_vld = tgl_s_r[2] ^ tgl_s_r[1];
   // opcode updates with its toggle, so it is stable at least one cycle before the toggle arrives
   logic is_es;
   logic is_er;
   logic is_ps;
   logic is_pr;
   assign is_es = cmd_vld && op_r == FSR_OP_ERS_SUSP;   // [R13]
   assign is_er = cmd_vld && op_r == FSR_OP_ERS_RESUM;  // [R13]
   assign is_ps = cmd_vld && op_r == FSR_OP_PGM_SUSP;   // [R14]
   assign is_pr = cmd_vld && op_r == FSR_OP_PGM_RESUM;
   // ****************************************
   // synchronise engine pins
   // ****************************************
   logic [1:0] es_s_r;
   logic [1:0] ps_s_r;
   logic [1:0] dn_s_r;
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         es_s_r <= 2'h0;
         ps_s_r <= 2'h0;
         dn_s_r <= 2'h0;
      end else begin
         es_s_r <= {es_s_r[0], i_ers_start};
         ps_s_r <= {ps_s_r[0], i_pgm_start};
         dn_s_r <= {dn_s_r[0], i_op_done};
      end
   end
   // ****************************************
   // sequencer
   // ****************************************
   fsr_state_t st_r;
   logic [8:0] lat_r;
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         st_r  <= FSR_IDLE;
         lat_r <= 9'h000;
      end else begin
         case (st_r)
            FSR_IDLE: begin
               if (es_s_r[1]) begin
                  st_r <= FSR_ERS_BUSY;
               end else if (ps_s_r[1]) begin
                  st_r <= FSR_PGM_BUSY;
               end
            end
            FSR_ERS_BUSY: begin
               if (dn_s_r[1]) begin
                  st_r <= FSR_IDLE;
               end else if (is_es) begin
                  st_r  <= FSR_ERS_SUSPING;
                  lat_r <= 9'h000;
               end
            end
            FSR_ERS_SUSPING: begin
               lat_r <= lat_r + 9'h001;
               if (lat_r == FSR_SUSP_CYC_W) begin
                  st_r <= FSR_ERS_SUSP;  // [R1]
               end
            end
            FSR_ERS_SUSP: begin
               // erase nesting not allowed: starts are ignored until resume
               if (is_er) begin
                  st_r <= FSR_ERS_BUSY;
               end
            end
            FSR_PGM_BUSY: begin
               if (dn_s_r[1]) begin
                  st_r <= FSR_IDLE;
               end else if (is_ps) begin
                  st_r  <= FSR_PGM_SUSPING;
                  lat_r <= 9'h000;
               end
            end
            FSR_PGM_SUSPING: begin
               lat_r <= lat_r + 9'h001;
               if (lat_r == FSR_SUSP_CYC_W) begin
                  st_r <= FSR_PGM_SUSP;  // [R3]
               end
            end
            FSR_PGM_SUSP: begin
               if (is_pr || is_er) begin
                  st_r <= FSR_PGM_BUSY;
               end
            end
            default: begin
               st_r <= FSR_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_stat <= '0;
      end else begin
         o_stat.ers_susp <= st_r == FSR_ERS_SUSP;
         o_stat.pgm_susp <= st_r == FSR_PGM_SUSP;
         o_stat.busy     <= st_r == FSR_ERS_BUSY || st_r == FSR_PGM_BUSY ||
                            st_r == FSR_ERS_SUSPING || st_r == FSR_PGM_SUSPING;
      end
   end
   // ****************************************
   // parameter dword table
   // ****************************************
   logic [7:0] base;
   logic [7:0] rel;
   assign base = i_tbl_alt ? FSR_ALT_BASE : FSR_DISC_BASE;  // [R11] [R12]
   assign rel  = i_tbl_addr - base;
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_tbl_data <= 8'h00;
         o_tbl_hit  <= 1'b0;
      end else begin
         // off-table offsets read as zero so a host scan sees a clean end
         o_tbl_hit  <= rel < DWORD_BYTES;
         o_tbl_data <= (rel < DWORD_BYTES) ? FSR_DWORD[rel[1:0]*8 +: 8] : 8'h00;  // [R9] [R10]
      end
   end
   // ****************************************
   // checks
   // ****************************************
   sequence s_es_go;
      st_r == FSR_ERS_BUSY && is_es && !dn_s_r[1];
   endsequence
   property p_es_lat;
      @(posedge i_sys_clk) disable iff (i_srst)
         s_es_go |-> ##[1:400] st_r == FSR_ERS_SUSP;
   endproperty
   a_es_lat: assert property (p_es_lat) else $error("erase suspend too slow"); // [R1]
   sequence s_ps_go;
      st_r == FSR_PGM_BUSY && is_ps && !dn_s_r[1];
   endsequence
   property p_ps_lat;
      @(posedge i_sys_clk) disable iff (i_srst)
         s_ps_go |-> ##[1:400] st_r == FSR_PGM_SUSP;
   endproperty
   a_ps_lat: assert property (p_ps_lat) else $error("program suspend too slow"); // [R3]
   // the top byte holds the support flag, the erase unit and the erase count
   property p_dword;
      @(posedge i_sys_clk) disable iff (i_srst)
         (!i_tbl_alt && i_tbl_addr == 8'h2F) |=>
            o_tbl_hit && !o_tbl_data[7] && o_tbl_data[6:5] == 2'h2 && o_tbl_data[4:0] == 5'h04;
   endproperty
   a_dword: assert property (p_dword) else $error("parameter dword wrong"); // [R9] [R10]
   property p_tbl;
      @(posedge i_sys_clk) disable iff (i_srst)
         (!i_tbl_alt && i_tbl_addr == FSR_DISC_BASE) |=> o_tbl_hit && o_tbl_data == 8'hEC;
   endproperty
   a_tbl: assert property (p_tbl) else $error("table byte wrong"); // [R11]
   property p_alt;
      @(posedge i_sys_clk) disable iff (i_srst)
         (i_tbl_alt && i_tbl_addr == 8'h31) |=> o_tbl_hit && o_tbl_data == 8'h44;
   endproperty
   a_alt: assert property (p_alt) else $error("alternate byte wrong"); // [R12]
   property p_resume;
      @(posedge i_sys_clk) disable iff (i_srst)
         (st_r == FSR_ERS_SUSP && is_er) |=> ##1 o_stat.busy && !o_stat.ers_susp;
   endproperty
   a_resume: assert property (p_resume) else $error("erase resume ignored"); // [R13]
   property p_hold;
      @(posedge i_sys_clk) disable iff (i_srst)
         (st_r == FSR_ERS_SUSP && !cmd_vld) |=> st_r == FSR_ERS_SUSP;
   endproperty
   a_hold: assert property (p_hold) else $error("erase suspend left without resume"); // [R5]
   property p_noearly;
      @(posedge i_sys_clk) disable iff (i_srst)
         s_es_go |=> (st_r != FSR_ERS_SUSP) [*8];
   endproperty
   a_noearly: assert property (p_noearly) else $error("erase suspended too early"); // [R1]
   // ****************************************
   // further checks
   // ****************************************
   property p_punit;
      @(posedge i_sys_clk) disable iff (i_srst)
         (!i_tbl_alt && i_tbl_addr == 8'h2E) |=> o_tbl_hit && o_tbl_data[3:2] == 2'h2 && o_tbl_data[7:4] == 4'h1;
   endproperty
   a_punit: assert property (p_punit) else $error("program unit byte wrong"); // [R10]
   property p_miss;
      @(posedge i_sys_clk) disable iff (i_srst)
         ((!i_tbl_alt && i_tbl_addr == 8'h30) || (i_tbl_alt && i_tbl_addr == 8'h2D)) |=>
            !o_tbl_hit && o_tbl_data == 8'h00;
   endproperty
   a_miss: assert property (p_miss) else $error("off-table byte not empty"); // [R11] [R12]
   property p_es_take;
      @(posedge i_sys_clk) disable iff (i_srst)
         s_es_go |=> st_r == FSR_ERS_SUSPING;
   endproperty
   a_es_take: assert property (p_es_take) else $error("erase suspend code not taken"); // [R13]
   property p_ps_take;
      @(posedge i_sys_clk) disable iff (i_srst)
         s_ps_go |=> st_r == FSR_PGM_SUSPING;
   endproperty
   a_ps_take: assert property (p_ps_take) else $error("program suspend code not taken"); // [R14]
   property p_ps_noearly;
      @(posedge i_sys_clk) disable iff (i_srst)
         s_ps_go |=> (st_r != FSR_PGM_SUSP) [*8];
   endproperty
   a_ps_noearly: assert property (p_ps_noearly) else $error("program suspended too early"); // [R3]
   property p_idle_ign;
      @(posedge i_sys_clk) disable iff (i_srst)
         (st_r == FSR_IDLE && cmd_vld) |=> st_r != FSR_ERS_SUSPING && st_r != FSR_PGM_SUSPING;
   endproperty
   a_idle_ign: assert property (p_idle_ign) else $error("suspend taken while idle"); // [R13] [R14]
   sequence s_pr_go;
      st_r == FSR_PGM_SUSP && (is_pr || is_er);
   endsequence
   property p_presume;
      @(posedge i_sys_clk) disable iff (i_srst)
         s_pr_go |=> ##1 o_stat.busy && !o_stat.pgm_susp;
   endproperty
   a_presume: assert property (p_presume) else $error("program resume ignored"); // [R13]
   property p_ps_hold;
      @(posedge i_sys_clk) disable iff (i_srst)
         (st_r == FSR_PGM_SUSP && !cmd_vld) |=> st_r == FSR_PGM_SUSP;
   endproperty
   a_ps_hold: assert property (p_ps_hold) else $error("program suspend left without resume"); // [R7]
   property p_excl;
      @(posedge i_sys_clk) disable iff (i_srst)
         !(o_stat.ers_susp && o_stat.pgm_susp);
   endproperty
   a_excl: assert property (p_excl) else $error("both kinds suspended at once"); // [R5] [R7]
endmodule : fsr_seq
`default_nettype wire

// ---- tb/flash_suspend_resume_timing_test.sv ----
// flash_suspend_resume_timing_test: self-checking bench for fsr_seq
// assumes fsr_host drives the link; array engine and table inputs come from here
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module flash_suspend_resume_timing_test import fsr_pkg::*;;
   // ****************************************
   // signals
   // ****************************************
   logic       i_sys_clk;
   logic       i_srst;
   logic       sck;
   logic       cs_n;
   logic       si;
   logic       ers_start;
   logic       pgm_start;
   logic       op_done;
   logic       tbl_alt;
   logic [7:0] tbl_addr;
   logic [7:0] tbl_data;
   logic       tbl_hit;
   fsr_stat_t  stat;
   int         error_cnt;
   int         num_checks;
   int         cnt;
   localparam logic [3:0][7:0] BYTES = {8'h44, 8'h18, 8'h83, 8'hEC};
   localparam logic [1:0][7:0] SUSP  = {FSR_OP_PGM_SUSP, FSR_OP_ERS_SUSP};
   localparam logic [1:0][7:0] RES   = {FSR_OP_ERS_RESUM, FSR_OP_PGM_RESUM};

   fsr_host u_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si));

   fsr_seq i_dut (
      .i_sys_clk  (i_sys_clk),
      .i_srst     (i_srst),
      .i_sck      (sck),
      .i_cs_n     (cs_n),
      .i_si       (si),
      .i_ers_start(ers_start),
      .i_pgm_start(pgm_start),
      .i_op_done  (op_done),
      .i_tbl_addr (tbl_addr),
      .i_tbl_alt  (tbl_alt),
      .o_tbl_data (tbl_data),
      .o_tbl_hit  (tbl_hit),
      .o_stat     (stat)
   );

   // ****************************************
   // tasks
   // ****************************************
   initial begin
      i_sys_clk = 1'b0;
      forever #50 i_sys_clk = ~i_sys_clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask : cyc
   // engine inputs are synchronised, so pulses last four cycles
   task automatic drive(input logic e, input logic p, input logic d);
      {ers_start, pgm_start, op_done} = {e, p, d};
      cyc(4);
      {ers_start, pgm_start, op_done} = 3'h0;
      cyc(4);
   endtask : drive
   task automatic rd_tbl(input logic alt, input logic [7:0] a, input logic [7:0] d, input logic h);
      tbl_alt  = alt;
      tbl_addr = a;
      cyc(2);
      `CHK(tbl_data, d)
      `CHK(tbl_hit, h)
   endtask : rd_tbl
   task automatic wait_susp(input int k);
      cnt = 0;
      while (((k == 0) ? stat.ers_susp : stat.pgm_susp) !== 1'b1 && cnt < 400) begin
         cyc(1);
         cnt++;
      end
   endtask : wait_susp
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   // ****************************************
   // tests
   // ****************************************
   initial begin
      {ers_start, pgm_start, op_done, tbl_alt, tbl_addr} = 12'h000;
      error_cnt = 0;
      num_checks = 0;
      // a rising reset clears the link side, whose clock is still
      i_srst = 1'b0;
      #1;
      i_srst = 1'b1;
      cyc(4);
      i_srst = 1'b0;
      cyc(2);
      `CHK(stat, 3'h0)
      for (int a = 0; a < 4; a++) begin
         rd_tbl(1'b0, FSR_DISC_BASE + 8'(a), BYTES[a], 1'b1);
         rd_tbl(1'b1, FSR_ALT_BASE + 8'(a), BYTES[a], 1'b1);
      end
      rd_tbl(1'b0, 8'h30, 8'h00, 1'b0);
      rd_tbl(1'b1, 8'h2D, 8'h00, 1'b0);
      rd_tbl(1'b1, 8'h32, 8'h00, 1'b0);
      $display("test table done");
      u_host.send_op(FSR_OP_ERS_SUSP);
      cyc(450);
      `CHK(stat, 3'h0)
      $display("test idle suspend done");
      for (int k = 0; k < 2; k++) begin
         drive(k == 0, k == 1, 1'b0);
         `CHK(stat.busy, 1'b1)
         for (int r = 0; r < 2; r++) begin
            u_host.send_op(SUSP[k]);
            wait_susp(k);
            `CHK(cnt < 400, 1'b1)
            drive(1'b1, k == 1, 1'b0);
            `CHK(stat[2:1], (k == 0) ? 2'h2 : 2'h1)
            if (k == 0) begin
               // the program resume code must not wake a suspended erase
               u_host.send_op(FSR_OP_PGM_RESUM);
               cyc(20);
               `CHK(stat, 3'h4)
            end
            u_host.send_op((k == 0) ? FSR_OP_ERS_RESUM : RES[r]);
            cyc(20);
            `CHK(stat, 3'h1)
            // resume-to-suspend spacing kept by the host
            cyc(1280);
         end
         drive(1'b0, 1'b0, 1'b1);
         `CHK(stat, 3'h0)
         $display("test suspend kind %0d done", k);
      end
      print_verdict();
   end
   initial begin
      #(100 * 20000);
      error_cnt++;
      print_verdict();
   end
endmodule : flash_suspend_resume_timing_test
`undef CHK
`default_nettype wire

// ---- tb/fsr_host.sv ----
// fsr_host: host-side serial controller model that sends one-byte commands
// assumes mode 0 framing, 30 ns link clock that stands low between frames
`timescale 1ns/1ps
`default_nettype none
module fsr_host (
   // serial link
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si
);
   // ****************************************
   // command frames
   // ****************************************
   initial begin
      o_sck  = 1'b0;
      o_cs_n = 1'b0;
      o_si   = 1'b0;
      // select rises once at start so the frame counter begins cleared
      #1 o_cs_n = 1'b1;
   end
   // only suspend and resume codes are sent, never a read of the array
   // odd start offset keeps the link out of phase with the system clock
   task automatic send_op(input logic [7:0] op);
      #7;
      o_cs_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         o_si = op[i]; // msb first
         #15 o_sck = 1'b1;
         #15 o_sck = 1'b0;
      end
      #15 o_cs_n = 1'b1;
      // released data line shows the inverse, not a stale copy
      o_si = ~o_si;
   endtask : send_op
endmodule : fsr_host
`default_nettype wire
